/* xps_pkg.sv */
// constants for the xdata pointer and fast port register bank
// assumes an 8-bit controller core on the same clock drives the register strobes
package xps_pkg;

	localparam int XPS_NPORT = 9;
	localparam int XPS_AW    = 24;

	// ==================================================================
	// register addresses on the special-function bus
	localparam logic [7:0] XPS_A_PTR0_LO  = 8'h82;
	localparam logic [7:0] XPS_A_PTR0_HI  = 8'h83;
	localparam logic [7:0] XPS_A_PTR1_LO  = 8'h84;
	localparam logic [7:0] XPS_A_PTR1_HI  = 8'h85;
	localparam logic [7:0] XPS_A_PTR_SEL  = 8'h86;
	localparam logic [7:0] XPS_A_PTR0_UP  = 8'h93;
	localparam logic [7:0] XPS_A_PTR1_UP  = 8'h95;
	localparam logic [7:0] XPS_A_IND_UP   = 8'hea;
	localparam logic [7:0] XPS_A_IND_MID  = 8'ha0;

	// ports 0..6, 12, 15 in that order
	localparam logic [8:0][7:0] XPS_A_PORT_OUT = {8'hf8, 8'he8, 8'hd8, 8'hc8, 8'hc0,
		8'hb0, 8'h98, 8'h90, 8'h80};
	localparam logic [8:0][7:0] XPS_A_PORT_PS  = {8'hf9, 8'he9, 8'hd9, 8'hc9, 8'hc1,
		8'hb1, 8'h99, 8'h91, 8'h89};
	localparam logic [8:0][7:0] XPS_A_PORT_SEL = {8'hfa, 8'hf2, 8'hda, 8'hca, 8'hc2,
		8'hb2, 8'h9a, 8'ha2, 8'h8a};

	// ==================================================================
	// reset values
	localparam logic [7:0] XPS_RST_BYTE = 8'h00;
	localparam logic       XPS_SEL_BIT  = 1'b0;

	// ==================================================================
	// xdata decode windows
	localparam logic [23:0] XPS_SRAM_LO  = 24'h000000;
	localparam logic [23:0] XPS_SRAM_HI  = 24'h001fff;
	localparam logic [23:0] XPS_IOP_LO   = 24'h005000;
	localparam logic [23:0] XPS_IOP_HI   = 24'h0051ff;
	localparam logic [23:0] XPS_EMC_LO   = 24'h005400;
	localparam logic [23:0] XPS_EMC_HI   = 24'h0054ff;
	localparam logic [23:0] XPS_ECC_LO   = 24'h080000;
	localparam logic [23:0] XPS_ECC_HI   = 24'h081fff;
	localparam logic [23:0] XPS_OFF_LO   = 24'h800000;

	typedef enum logic [2:0] {
		XPS_RG_NONE,
		XPS_RG_SRAM,
		XPS_RG_IOPORT,
		XPS_RG_EMICTL,
		XPS_RG_ECC,
		XPS_RG_OFFCHIP
	} xps_region_t;

endpackage : xps_pkg

/* xps_port.sv */
// one fast port: output, source select and synchronised pin state
// assumes pin levels are asynchronous and the hub output is on CLK_SYS
`timescale 1ns/1ps
module xps_port
	import xps_pkg::*;
#(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         wr_out,
	input  wire logic         wr_sel,
	input  wire logic [7:0]   wdata,
	input  wire logic [W-1:0] hub_out,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] out_q,
	output logic      [W-1:0] sel_q,
	output logic      [W-1:0] ps_q,
	output logic      [W-1:0] pad_q
);

	typedef struct packed {
		logic [W-1:0] out_r;
		logic [W-1:0] sel_r;
		logic [W-1:0] meta_r;
		logic [W-1:0] ps_r;
		logic [W-1:0] pad_r;
	} xps_port_st_t;

	xps_port_st_t st_r, st_nxt;

	always_comb begin
		st_nxt        = st_r;
		st_nxt.meta_r = pin_in;
		st_nxt.ps_r   = st_r.meta_r;
		if (wr_out) begin
			st_nxt.out_r = wdata[W-1:0];
		end
		if (wr_sel) begin
			st_nxt.sel_r = wdata[W-1:0];
		end
		for (int y = 0; y < W; y++) begin
			st_nxt.pad_r[y] = st_r.sel_r[y] ? st_r.out_r[y] : hub_out[y];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign out_q = st_r.out_r;
	assign sel_q = st_r.sel_r;
	assign ps_q  = st_r.ps_r;
	assign pad_q = st_r.pad_r;

	a_pad_source: assert property (@(posedge clk) disable iff (rst)
		##1 pad_q == ($past(sel_q) & $past(out_q) | ~$past(sel_q) & $past(hub_out)))
		else $error("pad not driven from selected source");

	a_ps_two_stage: assert property (@(posedge clk) disable iff (rst)
		##2 ps_q == $past(pin_in, 2))
		else $error("pin state does not follow pins after two stages");

endmodule : xps_port

/* xps_top.sv */
// data pointers, xdata address extension and decode, fast port registers
// assumes the core gives one-cycle strobes on CLK_SYS; pins are asynchronous
`timescale 1ns/1ps
module xps_top
	import xps_pkg::*;
#(
	parameter int NPORT = XPS_NPORT
) (
	input  wire logic               CLK_SYS,
	input  wire logic               SYS_RST,
	input  wire logic [7:0]         SFR_ADDR,
	input  wire logic               SFR_WR,
	input  wire logic               SFR_RD,
	input  wire logic [7:0]         SFR_WDATA,
	output logic      [7:0]         SFR_RDATA,
	output logic                    SFR_ACK,
	input  wire logic               PTR_INC,
	input  wire logic               PTR_LOAD,
	input  wire logic [15:0]        PTR_LOAD_DATA,
	output logic      [15:0]        PTR_VALUE,
	input  wire logic               XMOV_REQ,
	input  wire logic               XMOV_INDIRECT,
	input  wire logic [7:0]         XMOV_REG_VALUE,
	output logic      [23:0]        XADDR,
	output logic                    XADDR_VALID,
	output logic                    XSEL_SRAM,
	output logic                    XSEL_IOPORT,
	output logic                    XSEL_EMICTL,
	output logic                    XSEL_ECC,
	output logic                    XSEL_OFFCHIP,
	input  wire logic [NPORT*8-1:0] HUB_PORT_OUTPUT,
	input  wire logic [NPORT*8-1:0] PORT_PIN_IN,
	output logic      [NPORT*8-1:0] PORT_PIN_OUT
);

	// ==================================================================
	// decode helpers

	function automatic xps_region_t region_of(input logic [23:0] a);
		xps_region_t r;
		r = XPS_RG_NONE;
		if (a >= XPS_OFF_LO) begin
			r = XPS_RG_OFFCHIP;
		end else if (a <= XPS_SRAM_HI) begin
			r = XPS_RG_SRAM;
		end else if (a >= XPS_IOP_LO && a <= XPS_IOP_HI) begin
			r = XPS_RG_IOPORT;
		end else if (a >= XPS_EMC_LO && a <= XPS_EMC_HI) begin
			r = XPS_RG_EMICTL;
		end else if (a >= XPS_ECC_LO && a <= XPS_ECC_HI) begin
			r = XPS_RG_ECC;
		end
		return r;
	endfunction : region_of

	function automatic logic [NPORT-1:0] port_hit(input logic [7:0] a,
		input logic [8:0][7:0] tbl);
		logic [NPORT-1:0] h;
		h = '0;
		for (int p = 0; p < NPORT; p++) begin
			h[p] = (a == tbl[p]);
		end
		return h;
	endfunction : port_hit

	// ==================================================================
	// state

	typedef struct packed {
		logic        sel_r;
		logic [15:0] ptr0_r;
		logic [15:0] ptr1_r;
		logic [7:0]  ptr0_up_r;
		logic [7:0]  ptr1_up_r;
		logic [7:0]  ind_up_r;
		logic [7:0]  ind_mid_r;
		logic [7:0]  rdata_r;
		logic        ack_r;
		logic [15:0] ptr_val_r;
		logic [23:0] xaddr_r;
		logic        xvalid_r;
		logic [4:0]  xsel_r;
	} xps_st_t;

	xps_st_t st_r, st_nxt;

	logic [NPORT-1:0]   hit_out, hit_ps, hit_sel;
	logic [NPORT*8-1:0] port_out_q, port_sel_q, port_ps_q;

	assign hit_out = port_hit(SFR_ADDR, XPS_A_PORT_OUT);
	assign hit_ps  = port_hit(SFR_ADDR, XPS_A_PORT_PS);
	assign hit_sel = port_hit(SFR_ADDR, XPS_A_PORT_SEL);

	// ==================================================================
	// fast ports

	genvar gp;
	generate
		for (gp = 0; gp < NPORT; gp++) begin : g_port
			// three registers per port, pin state has no write path
			xps_port #(.W(8)) xps_port_inst (
				.clk     (CLK_SYS),
				.rst     (SYS_RST),
				.wr_out  (SFR_WR && hit_out[gp]),
				.wr_sel  (SFR_WR && hit_sel[gp]),
				.wdata   (SFR_WDATA),
				.hub_out (HUB_PORT_OUTPUT[gp*8 +: 8]),
				.pin_in  (PORT_PIN_IN[gp*8 +: 8]),
				.out_q   (port_out_q[gp*8 +: 8]),
				.sel_q   (port_sel_q[gp*8 +: 8]),
				.ps_q    (port_ps_q[gp*8 +: 8]),
				.pad_q   (PORT_PIN_OUT[gp*8 +: 8])
			);
		end
	endgenerate

	// ==================================================================
	// next state

	always_comb begin
		logic [15:0] cur_ptr;
		logic [23:0] xa;
		logic [7:0]  rd;
		logic        mapped;
		xps_region_t rg;
		logic [15:0] nv;

		st_nxt  = st_r;
		cur_ptr = st_r.sel_r ? st_r.ptr1_r : st_r.ptr0_r;
		xa      = '0;
		rd      = XPS_RST_BYTE;
		mapped  = 1'b1;
		rg      = XPS_RG_NONE;
		nv      = '0;

		// register writes; pointer instructions below take priority
		if (SFR_WR) begin
			unique case (SFR_ADDR)
				XPS_A_PTR0_LO: st_nxt.ptr0_r[7:0]  = SFR_WDATA;
				XPS_A_PTR0_HI: st_nxt.ptr0_r[15:8] = SFR_WDATA;
				XPS_A_PTR1_LO: st_nxt.ptr1_r[7:0]  = SFR_WDATA;
				XPS_A_PTR1_HI: st_nxt.ptr1_r[15:8] = SFR_WDATA;
				XPS_A_PTR_SEL: st_nxt.sel_r        = SFR_WDATA[0];
				XPS_A_PTR0_UP: st_nxt.ptr0_up_r    = SFR_WDATA;
				XPS_A_PTR1_UP: st_nxt.ptr1_up_r    = SFR_WDATA;
				XPS_A_IND_UP:  st_nxt.ind_up_r     = SFR_WDATA;
				XPS_A_IND_MID: st_nxt.ind_mid_r    = SFR_WDATA;
				default: ;
			endcase
		end

		// load and increment touch only the selected pointer
		if (PTR_LOAD || PTR_INC) begin
			nv = PTR_LOAD ? PTR_LOAD_DATA : 16'(cur_ptr + 16'h0001);
			if (st_r.sel_r) begin
				st_nxt.ptr1_r = nv;
			end else begin
				st_nxt.ptr0_r = nv;
			end
		end
		// code fetch and jump see only 16 bits, never the extensions
		st_nxt.ptr_val_r = cur_ptr;

		// read mux
		unique case (SFR_ADDR)
			XPS_A_PTR0_LO: rd = st_r.ptr0_r[7:0];
			XPS_A_PTR0_HI: rd = st_r.ptr0_r[15:8];
			XPS_A_PTR1_LO: rd = st_r.ptr1_r[7:0];
			XPS_A_PTR1_HI: rd = st_r.ptr1_r[15:8];
			XPS_A_PTR_SEL: rd = {7'h00, st_r.sel_r};
			XPS_A_PTR0_UP: rd = st_r.ptr0_up_r;
			XPS_A_PTR1_UP: rd = st_r.ptr1_up_r;
			XPS_A_IND_UP:  rd = st_r.ind_up_r;
			XPS_A_IND_MID: rd = st_r.ind_mid_r;
			default: mapped = 1'b0;
		endcase
		for (int p = 0; p < NPORT; p++) begin
			if (hit_out[p]) begin
				rd     = port_out_q[p*8 +: 8];
				mapped = 1'b1;
			end
			if (hit_sel[p]) begin
				rd     = port_sel_q[p*8 +: 8];
				mapped = 1'b1;
			end
			if (hit_ps[p]) begin
				rd     = port_ps_q[p*8 +: 8];
				mapped = 1'b1;
			end
		end
		st_nxt.ack_r = (SFR_RD || SFR_WR) && mapped;
		if (SFR_RD) begin
			st_nxt.rdata_r = mapped ? rd : XPS_RST_BYTE;
		end

		// external-data address formation
		if (XMOV_INDIRECT) begin
			xa = {st_r.ind_up_r, st_r.ind_mid_r, XMOV_REG_VALUE};
		end else begin
			xa = {(st_r.sel_r ? st_r.ptr1_up_r : st_r.ptr0_up_r), cur_ptr};
		end
		st_nxt.xvalid_r = XMOV_REQ;
		if (XMOV_REQ) begin
			st_nxt.xaddr_r = xa;
			rg             = region_of(xa);
			st_nxt.xsel_r  = {rg == XPS_RG_OFFCHIP, rg == XPS_RG_ECC,
				rg == XPS_RG_EMICTL, rg == XPS_RG_IOPORT, rg == XPS_RG_SRAM};
		end else begin
			st_nxt.xsel_r  = '0;
		end
	end

	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==================================================================
	// outputs

	assign SFR_RDATA    = st_r.rdata_r;
	assign SFR_ACK      = st_r.ack_r;
	assign PTR_VALUE    = st_r.ptr_val_r;
	assign XADDR        = st_r.xaddr_r;
	assign XADDR_VALID  = st_r.xvalid_r;
	assign XSEL_SRAM    = st_r.xsel_r[0];
	assign XSEL_IOPORT  = st_r.xsel_r[1];
	assign XSEL_EMICTL  = st_r.xsel_r[2];
	assign XSEL_ECC     = st_r.xsel_r[3];
	assign XSEL_OFFCHIP = st_r.xsel_r[4];

	// ==================================================================
	// checks

	a_inc_selected: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		(PTR_INC && !PTR_LOAD && !st_r.sel_r) |=> st_r.ptr0_r == 16'($past(st_r.ptr0_r) + 1))
		else $error("increment did not advance pointer zero");

	a_inc_other_kept: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		(PTR_INC && !SFR_WR && st_r.sel_r) |=> $stable(st_r.ptr0_r))
		else $error("unselected pointer changed on increment");

	a_ptr_ext_hi: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		(XMOV_REQ && !XMOV_INDIRECT) |=> XADDR[23:16] ==
		($past(st_r.sel_r) ? $past(st_r.ptr1_up_r) : $past(st_r.ptr0_up_r)))
		else $error("pointer move upper byte wrong");

	a_ptr_low16: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		(XMOV_REQ && !XMOV_INDIRECT) |=> XADDR[15:0] ==
		($past(st_r.sel_r) ? $past(st_r.ptr1_r) : $past(st_r.ptr0_r)))
		else $error("pointer move low bits wrong");

	a_ind_address: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		(XMOV_REQ && XMOV_INDIRECT) |=> XADDR ==
		{$past(st_r.ind_up_r), $past(st_r.ind_mid_r), $past(XMOV_REG_VALUE)})
		else $error("indirect move address wrong");

	a_valid_pulse: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		!XMOV_REQ |=> !XADDR_VALID && XSEL_SRAM == 1'b0 && XSEL_OFFCHIP == 1'b0)
		else $error("address strobe without move");

	a_sram_window: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		XADDR_VALID |-> XSEL_SRAM == (XADDR <= 24'h001fff))
		else $error("sram decode wrong");

	a_ioport_window: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		XADDR_VALID |-> XSEL_IOPORT == (XADDR >= 24'h005000 && XADDR <= 24'h0051ff))
		else $error("port control decode wrong");

	a_emictl_window: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		XADDR_VALID |-> XSEL_EMICTL == (XADDR >= 24'h005400 && XADDR <= 24'h0054ff))
		else $error("interface control decode wrong");

	a_ecc_window: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		XADDR_VALID |-> XSEL_ECC == (XADDR >= 24'h080000 && XADDR <= 24'h081fff))
		else $error("correction bytes decode wrong");

	a_offchip_half: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		XADDR_VALID |-> XSEL_OFFCHIP == XADDR[23])
		else $error("off-chip decode wrong");

	a_ps_no_write: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		(SFR_WR && SFR_ADDR == XPS_A_PORT_PS[0]) |=> port_out_q[7:0] == $past(port_out_q[7:0])
		&& port_sel_q[7:0] == $past(port_sel_q[7:0]))
		else $error("pin state write changed a register");

	// ==================================================================
	// pointer, register bus and xdata address checks

	a_load_ptr_zero: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		(PTR_LOAD && !st_r.sel_r) |=> st_r.ptr0_r == $past(PTR_LOAD_DATA))
		else $error("load missed pointer zero");

	a_load_ptr_one: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		(PTR_LOAD && st_r.sel_r) |=> st_r.ptr1_r == $past(PTR_LOAD_DATA))
		else $error("load missed pointer one");

	a_inc_ptr_one: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		(PTR_INC && !PTR_LOAD && st_r.sel_r) |=> st_r.ptr1_r == 16'($past(st_r.ptr1_r) + 1))
		else $error("increment did not advance pointer one");

	a_code_pointer: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		##1 PTR_VALUE == ($past(st_r.sel_r) ? $past(st_r.ptr1_r) : $past(st_r.ptr0_r)))
		else $error("code pointer not the selected 16 bits");

	a_ext_keeps_ptr: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		(SFR_WR && !PTR_LOAD && !PTR_INC && (SFR_ADDR == XPS_A_PTR0_UP ||
		SFR_ADDR == XPS_A_PTR1_UP)) |=> $stable(st_r.ptr0_r) && $stable(st_r.ptr1_r))
		else $error("extension write touched a pointer");

	a_ind_up_write: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		(SFR_WR && SFR_ADDR == XPS_A_IND_UP) |=> st_r.ind_up_r == $past(SFR_WDATA))
		else $error("upper byte write lost");

	a_ind_mid_write: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		(SFR_WR && SFR_ADDR == XPS_A_IND_MID) |=> st_r.ind_mid_r == $past(SFR_WDATA))
		else $error("middle byte write lost");

	a_xaddr_hold: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		!XMOV_REQ |=> $stable(XADDR))
		else $error("address changed without a move");

	a_xsel_onehot: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		XADDR_VALID |-> $onehot0({XSEL_SRAM, XSEL_IOPORT, XSEL_EMICTL, XSEL_ECC, XSEL_OFFCHIP}))
		else $error("more than one region selected");

	a_ack_idle: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		!(SFR_RD || SFR_WR) |=> !SFR_ACK)
		else $error("acknowledge without a strobe");

	a_sel_readback: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		(SFR_RD && SFR_ADDR == XPS_A_PTR_SEL) |=> SFR_ACK && SFR_RDATA == {7'h00, $past(st_r.sel_r)})
		else $error("select readback wrong");

	a_ps_readback: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		(SFR_RD && SFR_ADDR == XPS_A_PORT_PS[0]) |=> SFR_ACK && SFR_RDATA == $past(port_ps_q[7:0]))
		else $error("pin state readback wrong");

	a_rdata_hold: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		!SFR_RD |=> $stable(SFR_RDATA))
		else $error("read data changed without a read");

endmodule : xps_top

/* xps_core_model.sv */
// cpu core stand-in: register strobes, pointer operations and xdata moves
// assumes one shared clock; every request is held across exactly one sampling edge
`timescale 1ns/1ps
module xps_core_model (
	input  wire logic        clk,
	output logic      [7:0]  sfr_addr,
	output logic             sfr_wr,
	output logic             sfr_rd,
	output logic      [7:0]  sfr_wdata,
	output logic             ptr_inc,
	output logic             ptr_load,
	output logic      [15:0] ptr_load_data,
	output logic             xmov_req,
	output logic             xmov_indirect,
	output logic      [7:0]  xmov_reg_value
);
	initial begin
		{sfr_addr, sfr_wr, sfr_rd, sfr_wdata} = '0;
		{ptr_inc, ptr_load, ptr_load_data} = '0;
		{xmov_req, xmov_indirect, xmov_reg_value} = '0;
	end

	// ==================================================================
	// bus cycles; released lines show the inverse so stale values never match
	task automatic sfr(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr_addr  <= a;
		sfr_wdata <= d;
		sfr_wr    <= wr;
		sfr_rd    <= !wr;
		@(posedge clk);
		sfr_wr    <= 1'b0;
		sfr_rd    <= 1'b0;
		sfr_addr  <= ~a;
		sfr_wdata <= ~d;
	endtask : sfr

	task automatic ptr(input logic ld, input logic inc, input logic [15:0] d);
		@(posedge clk);
		ptr_load      <= ld;
		ptr_inc       <= inc;
		ptr_load_data <= d;
		@(posedge clk);
		ptr_load      <= 1'b0;
		ptr_inc       <= 1'b0;
		ptr_load_data <= ~d;
	endtask : ptr

	task automatic xmov(input logic ind, input logic [7:0] r);
		@(posedge clk);
		xmov_req       <= 1'b1;
		xmov_indirect  <= ind;
		xmov_reg_value <= r;
		@(posedge clk);
		xmov_req       <= 1'b0;
		xmov_indirect  <= ~ind;
		xmov_reg_value <= ~r;
	endtask : xmov
endmodule : xps_core_model

/* xps_top_tb.sv */
// self-checking bench for the pointer, xdata decode and fast port bank
// assumes xps_core_model drives the core side; pins and hub data come from here
`timescale 1ns/1ps
module xps_top_tb
	import xps_pkg::*;
;
	logic        clk_sys = 1'b0;
	logic        sys_rst = 1'b1;
	logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, xmov_reg_value, e0, e1;
	logic        sfr_wr, sfr_rd, sfr_ack, ptr_inc, ptr_load, xmov_req, xmov_indirect;
	logic        xaddr_valid;
	logic [15:0] ptr_load_data, ptr_value;
	logic [23:0] xaddr, a;
	logic [4:0]  xsel;
	logic [71:0] hub = '0;
	logic [71:0] pins = '0;
	logic [71:0] pin_out;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	logic [8:0]  rq[$];
	logic [28:0] xq[$];
	logic [8:0]  re;
	logic [28:0] xe;
	logic [7:0]  o_v[9], s_v[9];
	logic [7:0]  ra[9] = '{XPS_A_PTR_SEL, XPS_A_PTR0_UP, XPS_A_PTR1_UP, XPS_A_IND_UP,
		XPS_A_IND_MID, XPS_A_PTR0_LO, XPS_A_PTR0_HI, XPS_A_PTR1_LO, XPS_A_PTR1_HI};
	logic [23:0] da[14] = '{24'h000000, 24'h001fff, 24'h002000, 24'h005000, 24'h0051ff,
		24'h005200, 24'h005400, 24'h0054ff, 24'h080000, 24'h081fff, 24'h082000,
		24'h7fffff, 24'h800000, 24'hffffff};

	always #2.5 clk_sys = ~clk_sys;

	xps_top xps_top_inst (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .SFR_ADDR(sfr_addr),
		.SFR_WR(sfr_wr), .SFR_RD(sfr_rd), .SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata),
		.SFR_ACK(sfr_ack), .PTR_INC(ptr_inc), .PTR_LOAD(ptr_load),
		.PTR_LOAD_DATA(ptr_load_data), .PTR_VALUE(ptr_value), .XMOV_REQ(xmov_req),
		.XMOV_INDIRECT(xmov_indirect), .XMOV_REG_VALUE(xmov_reg_value), .XADDR(xaddr),
		.XADDR_VALID(xaddr_valid), .XSEL_SRAM(xsel[4]), .XSEL_IOPORT(xsel[3]),
		.XSEL_EMICTL(xsel[2]), .XSEL_ECC(xsel[1]), .XSEL_OFFCHIP(xsel[0]),
		.HUB_PORT_OUTPUT(hub), .PORT_PIN_IN(pins), .PORT_PIN_OUT(pin_out));

	xps_core_model xps_core_model_inst (.clk(clk_sys), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .ptr_inc(ptr_inc),
		.ptr_load(ptr_load), .ptr_load_data(ptr_load_data), .xmov_req(xmov_req),
		.xmov_indirect(xmov_indirect), .xmov_reg_value(xmov_reg_value));

	// ==================================================================
	// shared helpers
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up

	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		rq.push_back(9'h000);
		xps_core_model_inst.sfr(1'b1, ad, d);
	endtask : wr

	task automatic rd(input logic [7:0] ad, input logic [7:0] e);
		rq.push_back({1'b1, e});
		xps_core_model_inst.sfr(1'b0, ad, 8'h00);
	endtask : rd

	// independent decode: {sram, ioport, emictl, ecc, offchip}
	function automatic logic [4:0] region(input logic [23:0] x);
		return {x <= 24'h001fff, x >= 24'h005000 && x <= 24'h0051ff,
			x >= 24'h005400 && x <= 24'h0054ff, x >= 24'h080000 && x <= 24'h081fff,
			x >= 24'h800000};
	endfunction : region

	task automatic xm(input logic ind, input logic [7:0] r, input logic [23:0] e);
		xq.push_back({e, region(e)});
		xps_core_model_inst.xmov(ind, r);
	endtask : xm

	// ==================================================================
	// result watcher: oldest note is matched against each answer
	always @(posedge clk_sys) begin
		if (sfr_ack === 1'b1) begin
			if (rq.size() == 0) chk("stray ack", 32'h0, 32'h1);
			else begin
				re = rq.pop_front();
				if (re[8]) chk("sfr read", 32'(re[7:0]), 32'(sfr_rdata));
			end
		end
		if (xaddr_valid === 1'b1) begin
			if (xq.size() == 0) chk("stray move", 32'h0, 32'h1);
			else begin
				xe = xq.pop_front();
				chk("xdata move", 32'(xe), 32'({xaddr, xsel}));
			end
		end
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		wrap_up();
	end

	// ==================================================================
	// main sequence
	initial begin
		void'($urandom(26));
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		foreach (ra[i]) rd(ra[i], 8'h00);
		for (int k = 0; k < 9; k++) begin
			rd(XPS_A_PORT_OUT[k], 8'h00);
			rd(XPS_A_PORT_SEL[k], 8'h00);
			rd(XPS_A_PORT_PS[k], 8'h00);
		end
		// pointer select routes load and increment
		xps_core_model_inst.ptr(1'b1, 1'b0, 16'h1234);
		wr(XPS_A_PTR_SEL, 8'hff);
		rd(XPS_A_PTR_SEL, 8'h01);
		xps_core_model_inst.ptr(1'b1, 1'b0, 16'habff);
		xps_core_model_inst.ptr(1'b0, 1'b1, 16'h0000);
		rd(XPS_A_PTR0_LO, 8'h34);
		rd(XPS_A_PTR0_HI, 8'h12);
		rd(XPS_A_PTR1_LO, 8'h00);
		rd(XPS_A_PTR1_HI, 8'hac);
		e0 = 8'($urandom);
		e1 = 8'($urandom);
		wr(XPS_A_PTR0_UP, e0);
		wr(XPS_A_PTR1_UP, e1);
		wr(XPS_A_IND_UP, 8'h5a);
		repeat (2) @(posedge clk_sys);
		chk("pointer value", 32'h0000ac00, 32'(ptr_value));
		xm(1'b0, 8'h77, {e1, 16'hac00});
		wr(XPS_A_PTR_SEL, 8'h00);
		xm(1'b0, 8'h77, {e0, 16'h1234});
		// load beats increment, then pointer zero advances alone
		xps_core_model_inst.ptr(1'b1, 1'b1, 16'hfffe);
		xps_core_model_inst.ptr(1'b0, 1'b1, 16'h0000);
		rd(XPS_A_PTR0_LO, 8'hff);
		rd(XPS_A_PTR0_HI, 8'hff);
		rd(XPS_A_PTR1_HI, 8'hac);
		chk("pointer value", 32'h0000ffff, 32'(ptr_value));
		// region edges first, then random indirect addresses
		for (int i = 0; i < 18; i++) begin
			a = (i < 14) ? da[i] : 24'($urandom);
			wr(XPS_A_IND_UP, a[23:16]);
			wr(XPS_A_IND_MID, a[15:8]);
			xm(1'b1, a[7:0], a);
		end
		// fast ports: per-pin source choice
		for (int k = 0; k < 9; k++) begin
			o_v[k] = 8'($urandom);
			s_v[k] = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($urandom);
			wr(XPS_A_PORT_OUT[k], o_v[k]);
			wr(XPS_A_PORT_SEL[k], s_v[k]);
			rd(XPS_A_PORT_OUT[k], o_v[k]);
			rd(XPS_A_PORT_SEL[k], s_v[k]);
		end
		for (int p = 0; p < 2; p++) begin
			for (int k = 0; k < 9; k++) hub[8*k+:8] <= 8'($urandom);
			repeat (3) @(posedge clk_sys);
			for (int k = 0; k < 9; k++)
				chk("pin out", 32'((s_v[k] & o_v[k]) | (~s_v[k] & hub[8*k+:8])),
					32'(pin_out[8*k+:8]));
		end
		// pin state follows pins and ignores writes
		for (int k = 0; k < 9; k++) pins[8*k+:8] <= 8'($urandom);
		repeat (3) @(posedge clk_sys);
		for (int k = 0; k < 9; k++) begin
			rd(XPS_A_PORT_PS[k], pins[8*k+:8]);
			wr(XPS_A_PORT_PS[k], ~pins[8*k+:8]);
			rd(XPS_A_PORT_PS[k], pins[8*k+:8]);
		end
		// unmapped place: no acknowledge, zero data
		xps_core_model_inst.sfr(1'b0, 8'h87, 8'h00);
		#1;
		chk("unmapped ack", 32'h0, 32'(sfr_ack));
		chk("unmapped data", 32'h0, 32'(sfr_rdata));
		repeat (4) @(posedge clk_sys);
		chk("pending notes", 32'h0, 32'(rq.size() + xq.size()));
		wrap_up();
	end
endmodule : xps_top_tb
